// >>> rtl/txdl_dma.sv
// transmit descriptor list engine of one channel
`timescale 1ns/1ps
module txdl_dma
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_init_tx_cmd,
  input wire logic i_tx_poll_cmd,
  input wire logic i_tx_reset_cmd,
  input wire logic i_list_end_mode,
  input wire logic [31:0] i_base_addr,
  input wire logic [31:0] i_last_tx_desc_addr,
  input wire logic i_last_addr_wr,
  input wire logic [31:0] i_branch_tx_desc_addr,
  output logic o_mem_rd_req,
  output logic [31:0] o_mem_rd_addr,
  output logic [2:0] o_mem_rd_len,
  input wire logic i_mem_rd_ack,
  input wire logic i_mem_rd_valid,
  input wire logic [31:0] i_mem_rd_data,
  output logic o_mem_wr_req,
  output logic [31:0] o_mem_wr_addr,
  output logic [31:0] o_mem_wr_data,
  input wire logic i_mem_wr_ack,
  output logic o_fifo_valid,
  output logic [31:0] o_fifo_data,
  output logic [2:0] o_fifo_bytes,
  output logic o_fifo_frame_end,
  input wire logic i_fifo_ready,
  output logic o_active,
  output logic [31:0] o_cur_desc_addr,
  output logic o_irq,
  output logic o_irq_host,
  output logic o_irq_err
);

  txdl_pkg::txdl_state_t state;
  logic [31:0] cur_addr;
  logic [31:0] link;
  logic [31:0] data_ptr;
  logic [12:0] remain;
  logic frame_end_flag;
  logic hold_flag;
  logic host_irq_request;
  logic [1:0] beat;
  logic parked;
  logic abort_pend;
  logic abort_is_reset;
  logic push_valid;
  logic [31:0] push_data;
  logic [2:0] push_bytes;
  logic push_fe;
  logic fifo_in_ready;
  logic [31:0] al_data;
  logic [2:0] al_bytes;
  logic abort_cmd;

  assign o_cur_desc_addr = cur_addr;
  // an init or transmitter reset command while busy is taken as an abort of the descriptor in hand
  assign abort_cmd = (i_tx_reset_cmd || i_init_tx_cmd) && (state != txdl_pkg::S_IDLE);

  txdl_aligner u_aligner
  (
    .i_word(i_mem_rd_data),
    .i_offset(data_ptr[1:0]),
    .i_remain(remain),
    .o_data(al_data),
    .o_bytes(al_bytes)
  );

  txdl_fifo
  #(
    .WIDTH(txdl_pkg::FIFO_WIDTH),
    .DEPTH(txdl_pkg::FIFO_DEPTH)
  )
  u_fifo
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(push_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data({push_fe, push_bytes, push_data}),
    .o_out_valid(o_fifo_valid),
    .o_out_data({o_fifo_frame_end, o_fifo_bytes, o_fifo_data}),
    .i_out_ready(i_fifo_ready)
  );

  // abort bookkeeping; a new command beats the clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      abort_pend <= 1'b0;
      abort_is_reset <= 1'b0;
    end
    else if (abort_cmd)
    begin
      abort_pend <= 1'b1;
      abort_is_reset <= i_tx_reset_cmd;
    end
    else if (state == txdl_pkg::S_NEXT || state == txdl_pkg::S_IDLE)
    begin
      // a command caught while parking must not abort the next start
      abort_pend <= 1'b0;
      abort_is_reset <= 1'b0;
    end
  end

  // main sequencer
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      state <= txdl_pkg::S_IDLE;
      cur_addr <= txdl_pkg::ADDR_RST;
      link <= txdl_pkg::ADDR_RST;
      data_ptr <= txdl_pkg::ADDR_RST;
      remain <= txdl_pkg::REM_RST;
      frame_end_flag <= 1'b0;
      hold_flag <= 1'b0;
      host_irq_request <= 1'b0;
      beat <= 2'h0;
      parked <= 1'b0;
    end
    else
    begin
      unique case (state)
        txdl_pkg::S_IDLE:
        begin
          if (i_init_tx_cmd)
          begin
            cur_addr <= txdl_pkg::txdl_word_align(i_base_addr);
            parked <= 1'b0;
            state <= txdl_pkg::S_DREQ;
          end
          else if (parked && (i_tx_poll_cmd || i_last_addr_wr))
          begin
            // resume at the saved link: the parked descriptor's, or the branch address after a transmitter reset
            cur_addr <= txdl_pkg::txdl_word_align(link);
            parked <= 1'b0;
            state <= txdl_pkg::S_DREQ;
          end
        end
        txdl_pkg::S_DREQ:
        begin
          beat <= 2'h0;
          state <= txdl_pkg::S_DRD;
        end
        txdl_pkg::S_DRD:
        begin
          if (i_mem_rd_valid)
          begin
            beat <= beat + 2'h1;
            unique case (beat)
              2'h0:
              begin
                frame_end_flag <= i_mem_rd_data[txdl_pkg::FE_BIT];
                hold_flag <= i_mem_rd_data[txdl_pkg::HOLD_BIT];
                host_irq_request <= i_mem_rd_data[txdl_pkg::HI_BIT];
                remain <= i_mem_rd_data[txdl_pkg::CNT_LSB +: txdl_pkg::CNT_W];
              end
              2'h1:
              begin
                link <= i_mem_rd_data;
              end
              default:
              begin
                data_ptr <= i_mem_rd_data;
                state <= txdl_pkg::S_CHK;
              end
            endcase
          end
        end
        txdl_pkg::S_CHK:
        begin
          if (abort_pend || abort_cmd)
          begin
            state <= txdl_pkg::S_WB;
          end
          else if (remain == txdl_pkg::REM_RST)
          begin
            // empty section: a lone frame end still goes through the fifo
            state <= frame_end_flag ? txdl_pkg::S_PUSH : txdl_pkg::S_WB;
          end
          else
          begin
            state <= txdl_pkg::S_XREQ;
          end
        end
        txdl_pkg::S_XREQ:
        begin
          if (abort_pend || abort_cmd)
          begin
            state <= txdl_pkg::S_WB;
          end
          else if (fifo_in_ready)
          begin
            state <= txdl_pkg::S_XRD;
          end
        end
        txdl_pkg::S_XRD:
        begin
          // an abort waits for the outstanding word so no beat is left behind
          if (i_mem_rd_valid)
          begin
            data_ptr <= data_ptr + 32'(al_bytes);
            remain <= remain - 13'(al_bytes);
            state <= txdl_pkg::S_PUSH;
          end
        end
        txdl_pkg::S_PUSH:
        begin
          if (abort_pend || abort_cmd)
          begin
            state <= txdl_pkg::S_WB;
          end
          else if (fifo_in_ready)
          begin
            state <= (remain == txdl_pkg::REM_RST) ? txdl_pkg::S_WB : txdl_pkg::S_XREQ;
          end
        end
        txdl_pkg::S_WB:
        begin
          if (o_mem_wr_req && i_mem_wr_ack)
          begin
            state <= txdl_pkg::S_NEXT;
          end
        end
        txdl_pkg::S_NEXT:
        begin
          if (abort_pend)
          begin
            // the link read for this descriptor is ignored
            link <= i_branch_tx_desc_addr;
            cur_addr <= txdl_pkg::txdl_word_align(i_branch_tx_desc_addr);
            parked <= abort_is_reset;
            state <= abort_is_reset ? txdl_pkg::S_IDLE : txdl_pkg::S_DREQ;
          end
          else if (!i_list_end_mode && hold_flag)
          begin
            parked <= 1'b1;
            state <= txdl_pkg::S_IDLE;
          end
          else if (i_list_end_mode && (cur_addr == i_last_tx_desc_addr))
          begin
            parked <= 1'b1;
            state <= txdl_pkg::S_IDLE;
          end
          else
          begin
            cur_addr <= txdl_pkg::txdl_word_align(link);
            state <= txdl_pkg::S_DREQ;
          end
        end
      endcase
    end
  end

  // memory read port: request held until acknowledged
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_mem_rd_req <= 1'b0;
      o_mem_rd_addr <= txdl_pkg::ADDR_RST;
      o_mem_rd_len <= 3'h0;
    end
    else if (o_mem_rd_req && i_mem_rd_ack)
    begin
      o_mem_rd_req <= 1'b0;
    end
    else if (state == txdl_pkg::S_DREQ)
    begin
      o_mem_rd_req <= 1'b1;
      o_mem_rd_addr <= cur_addr;
      o_mem_rd_len <= txdl_pkg::RD_LEN_DESC;
    end
    else if (state == txdl_pkg::S_XREQ && fifo_in_ready && !abort_pend && !abort_cmd)
    begin
      o_mem_rd_req <= 1'b1;
      o_mem_rd_addr <= txdl_pkg::txdl_word_align(data_ptr);
      o_mem_rd_len <= txdl_pkg::RD_LEN_DATA;
    end
  end

  // fifo load; the frame end tag rides on the entry that empties the section
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      push_valid <= 1'b0;
      push_data <= 32'h0000_0000;
      push_bytes <= 3'h0;
      push_fe <= 1'b0;
    end
    else if (state == txdl_pkg::S_XRD && i_mem_rd_valid && !abort_pend && !abort_cmd)
    begin
      push_valid <= 1'b1;
      push_data <= al_data;
      push_bytes <= al_bytes;
      push_fe <= frame_end_flag && ({10'h000, al_bytes} == remain);
    end
    else if (state == txdl_pkg::S_CHK && remain == txdl_pkg::REM_RST && frame_end_flag
             && !abort_pend && !abort_cmd)
    begin
      push_valid <= 1'b1;
      push_data <= 32'h0000_0000;
      push_bytes <= 3'h0;
      push_fe <= 1'b1;
    end
    else if (fifo_in_ready || abort_pend || abort_cmd)
    begin
      push_valid <= 1'b0;
    end
  end

  // write-back of the fourth word
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_mem_wr_req <= 1'b0;
      o_mem_wr_addr <= txdl_pkg::ADDR_RST;
      o_mem_wr_data <= 32'h0000_0000;
    end
    else if (o_mem_wr_req && i_mem_wr_ack)
    begin
      o_mem_wr_req <= 1'b0;
    end
    else if (state == txdl_pkg::S_WB && !o_mem_wr_req)
    begin
      o_mem_wr_req <= 1'b1;
      o_mem_wr_addr <= cur_addr + txdl_pkg::WB_OFFSET;
      o_mem_wr_data <= txdl_pkg::WB_WORD;
    end
  end

  // interrupt pulses and activity flag
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_irq <= 1'b0;
      o_irq_host <= 1'b0;
      o_irq_err <= 1'b0;
      o_active <= 1'b0;
    end
    else
    begin
      o_active <= (state != txdl_pkg::S_IDLE);
      o_irq_err <= (state == txdl_pkg::S_CHK) && (remain == txdl_pkg::REM_RST)
                   && !frame_end_flag && !abort_pend && !abort_cmd;
      // only a section that ran to its end earns the host interrupt
      o_irq_host <= (state == txdl_pkg::S_WB) && o_mem_wr_req && i_mem_wr_ack
                    && host_irq_request && !abort_pend;
      o_irq <= ((state == txdl_pkg::S_CHK) && (remain == txdl_pkg::REM_RST)
                && !frame_end_flag && !abort_pend && !abort_cmd)
               || ((state == txdl_pkg::S_WB) && o_mem_wr_req && i_mem_wr_ack
                   && host_irq_request && !abort_pend);
    end
  end

  AST_DESC_BURST:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == txdl_pkg::S_DREQ |=> o_mem_rd_req && o_mem_rd_len == txdl_pkg::RD_LEN_DESC
        && o_mem_rd_addr == cur_addr)
    else $error("descriptor fetch is not a three word burst at the current address");

  AST_WORD_ALIGNED:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_mem_rd_req || o_mem_wr_req |-> o_mem_rd_addr[1:0] == 2'h0 && o_mem_wr_addr[1:0] == 2'h0)
    else $error("memory access not word aligned");

  AST_WRITE_BACK:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(o_mem_wr_req) |-> o_mem_wr_addr == cur_addr + txdl_pkg::WB_OFFSET
        && o_mem_wr_data[txdl_pkg::CMPL_BIT] && $past(state == txdl_pkg::S_WB))
    else $error("write-back word wrong");

  AST_IDLE_NO_FETCH:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == txdl_pkg::S_IDLE && !i_init_tx_cmd && !i_tx_poll_cmd && !i_last_addr_wr
        |=> state == txdl_pkg::S_IDLE)
    else $error("fetch started without a command");

  AST_HOLD_PARKS:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == txdl_pkg::S_NEXT && !abort_pend && !i_list_end_mode && hold_flag
        |=> state == txdl_pkg::S_IDLE ##1 !o_active)
    else $error("hold flag did not park the channel");

  AST_LAST_PARKS:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == txdl_pkg::S_NEXT && !abort_pend && i_list_end_mode
        && cur_addr == i_last_tx_desc_addr |=> state == txdl_pkg::S_IDLE && parked)
    else $error("last address match did not park the channel");

  AST_BRANCH_LINK:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == txdl_pkg::S_NEXT && !abort_pend && !hold_flag && !i_list_end_mode
        |=> state == txdl_pkg::S_DREQ && cur_addr == {$past(link[31:2]), 2'h0})
    else $error("branch did not follow the link");

  AST_ABORT_BRANCH:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == txdl_pkg::S_NEXT && abort_pend |=> link == $past(i_branch_tx_desc_addr))
    else $error("abort did not take the branch address");

  AST_EMPTY_ERROR:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      state == txdl_pkg::S_CHK && remain == 13'h0000 && !frame_end_flag
        && !abort_pend && !abort_cmd |=> o_irq_err && o_irq ##1 !o_irq_err)
    else $error("empty descriptor did not raise the error interrupt");

  AST_HOST_IRQ:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_irq_host |-> $past(host_irq_request) && remain == 13'h0000 && o_irq)
    else $error("host interrupt before the section finished");

  AST_FE_LAST:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      push_valid && push_fe |-> remain == 13'h0000 && frame_end_flag)
    else $error("frame end tag on an entry that is not the last");

endmodule

// >>> rtl/txdl_pkg.sv
// constants and types shared by the transmit descriptor list engine
package txdl_pkg;

  // descriptor layout: four words, the first three fetched in one burst
  localparam int unsigned DESC_WORDS = 4;
  localparam logic [2:0] RD_LEN_DESC = 3'h3;
  localparam logic [2:0] RD_LEN_DATA = 3'h1;
  localparam logic [31:0] WB_OFFSET = 32'h0000_000C;

  // word zero fields
  localparam int unsigned FE_BIT = 31;
  localparam int unsigned HOLD_BIT = 30;
  localparam int unsigned HI_BIT = 29;
  localparam int unsigned CNT_LSB = 16;
  localparam int unsigned CNT_W = 13;

  // word three: completion flag
  localparam int unsigned CMPL_BIT = 30;
  localparam logic [31:0] WB_WORD = 32'h0000_0001 << CMPL_BIT;

  // reset values
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [12:0] REM_RST = 13'h0000;

  // transmit fifo entry: data, valid byte count, frame end tag
  localparam int unsigned BYTES_W = 3;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_WIDTH = 32 + BYTES_W + 1;

  typedef enum logic [8:0]
  {
    S_IDLE = 9'h001,
    S_DREQ = 9'h002,
    S_DRD  = 9'h004,
    S_CHK  = 9'h008,
    S_XREQ = 9'h010,
    S_XRD  = 9'h020,
    S_PUSH = 9'h040,
    S_WB   = 9'h080,
    S_NEXT = 9'h100
  } txdl_state_t;

  function automatic logic [31:0] txdl_word_align(input logic [31:0] addr);
    return {addr[31:2], 2'h0};
  endfunction

endpackage

// >>> rtl/txdl_aligner.sv
// drops the leading bytes of a fetched word and sizes the useful part
`timescale 1ns/1ps
module txdl_aligner
(
  input wire logic [31:0] i_word,
  input wire logic [1:0] i_offset,
  input wire logic [12:0] i_remain,
  output logic [31:0] o_data,
  output logic [2:0] o_bytes
);

  logic [2:0] room;

  always_comb
  begin
    room = 3'h4 - {1'b0, i_offset};
    // lowest address sits in bits 7:0, so a right shift discards bytes below the start
    o_data = i_word >> {i_offset, 3'h0};
    if ({10'h000, room} > i_remain)
    begin
      o_bytes = i_remain[2:0];
    end
    else
    begin
      o_bytes = room;
    end
  end

endmodule

// >>> rtl/txdl_fifo.sv
// synchronous fifo with a registered head word
`timescale 1ns/1ps
module txdl_fifo
#(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 16
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign do_wr = i_in_valid && o_in_ready;
  // the head register refills whenever it is empty or being taken and the fifo still holds an entry
  assign do_rd = (count != '0) && (!o_out_valid || i_out_ready);

  always_ff @(posedge i_clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (do_rd)
      begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_out_valid <= 1'b0;
      o_out_data <= '0;
    end
    else if (do_rd)
    begin
      o_out_valid <= 1'b1;
      o_out_data <= mem[rd_ptr];
    end
    else if (i_out_ready)
    begin
      o_out_valid <= 1'b0;
    end
  end

  AST_FIFO_NO_OVERRUN:
    assert property (@(posedge i_clk) disable iff (!i_reset_n)
      count == (AW+1)'(DEPTH) && i_in_valid |=> $stable(wr_ptr))
    else $error("fifo accepted a word while full");

endmodule

// >>> tb/txdl_mem_model.sv
// host memory model: descriptor bursts, data words and write-backs
`timescale 1ns/1ps
module txdl_mem_model
(
  input wire logic i_clk,
  input wire logic [1:0] i_delay,
  input wire logic i_rd_req,
  input wire logic [31:0] i_rd_addr,
  input wire logic [2:0] i_rd_len,
  output logic o_rd_ack,
  output logic o_rd_valid,
  output logic [31:0] o_rd_data,
  input wire logic i_wr_req,
  input wire logic [31:0] i_wr_addr,
  input wire logic [31:0] i_wr_data,
  output logic o_wr_ack
);
  logic [31:0] mem [0:4095];
  logic [31:0] a;
  logic [2:0] n;
  initial
  begin
    o_rd_ack = 1'b0;
    o_rd_valid = 1'b0;
    o_rd_data = 32'h0000_0000;
    o_wr_ack = 1'b0;
  end
  // words return in address order after the ack
  always
  begin
    @(posedge i_clk);
    if (i_rd_req === 1'b1)
    begin
      a = i_rd_addr;
      n = i_rd_len;
      repeat (i_delay) @(posedge i_clk);
      o_rd_ack <= 1'b1;
      @(posedge i_clk);
      o_rd_ack <= 1'b0;
      repeat (n)
      begin
        o_rd_valid <= 1'b1;
        o_rd_data <= mem[a[13:2]];
        a = a + 32'h4;
        @(posedge i_clk);
      end
      o_rd_valid <= 1'b0;
      // released bus shows no stale word
      o_rd_data <= ~o_rd_data;
    end
  end
  // write-back lands in memory on the ack edge
  always
  begin
    @(posedge i_clk);
    if (i_wr_req === 1'b1)
    begin
      repeat (i_delay) @(posedge i_clk);
      mem[i_wr_addr[13:2]] = i_wr_data;
      o_wr_ack <= 1'b1;
      @(posedge i_clk);
      o_wr_ack <= 1'b0;
    end
  end
endmodule

// >>> tb/test_tx_descriptor_list_dma.sv
// self-checking bench for the transmit descriptor list engine
`timescale 1ns/1ps
module test_tx_descriptor_list_dma;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic init = 1'b0, poll = 1'b0, trst = 1'b0, mode = 1'b0, last_wr = 1'b0;
  logic ready = 1'b0, stall = 1'b1;
  logic [1:0] delay = 2'h0;
  logic [31:0] base = 32'h0, last = 32'h0, branch = 32'h0;
  logic rd_req, rd_ack, rd_valid, wr_req, wr_ack, f_valid, f_fe, active, irq, irq_h, irq_e;
  logic [2:0] rd_len, f_bytes;
  logic [31:0] rd_addr, rd_data, wr_addr, wr_data, f_data, cur, m, w;
  logic [35:0] e;
  logic [35:0] fq[$];
  logic [31:0] wq[$];
  int seed = 58;
  int n_fail = 0;
  int compares = 0;
  int exp_hi = 0, exp_err = 0, seen_hi = 0, seen_err = 0;
  bit free_run = 1'b0;

  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) ready <= stall ? 1'b0 : 1'($random(seed));

  txdl_dma dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_init_tx_cmd(init),
    .i_tx_poll_cmd(poll), .i_tx_reset_cmd(trst), .i_list_end_mode(mode), .i_base_addr(base),
    .i_last_tx_desc_addr(last), .i_last_addr_wr(last_wr), .i_branch_tx_desc_addr(branch),
    .o_mem_rd_req(rd_req), .o_mem_rd_addr(rd_addr), .o_mem_rd_len(rd_len),
    .i_mem_rd_ack(rd_ack), .i_mem_rd_valid(rd_valid), .i_mem_rd_data(rd_data),
    .o_mem_wr_req(wr_req), .o_mem_wr_addr(wr_addr), .o_mem_wr_data(wr_data),
    .i_mem_wr_ack(wr_ack), .o_fifo_valid(f_valid), .o_fifo_data(f_data),
    .o_fifo_bytes(f_bytes), .o_fifo_frame_end(f_fe), .i_fifo_ready(ready), .o_active(active),
    .o_cur_desc_addr(cur), .o_irq(irq), .o_irq_host(irq_h), .o_irq_err(irq_e));
  txdl_mem_model mem_u (.i_clk(i_clk), .i_delay(delay), .i_rd_req(rd_req),
    .i_rd_addr(rd_addr), .i_rd_len(rd_len), .o_rd_ack(rd_ack), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .i_wr_req(wr_req), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .o_wr_ack(wr_ack));

  task report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // host side: builds one descriptor and its data, notes what should come out
  task automatic mk_desc(input logic [31:0] at, input logic [2:0] flags, input logic [12:0] cnt,
    input logic [31:0] link, input logic [31:0] ptr, input bit ex);
    logic [31:0] a;
    logic [31:0] d;
    int off;
    int rem;
    int b;
    mem_u.mem[at[13:2]] = {flags, cnt, 16'h0000};
    mem_u.mem[at[13:2] + 1] = link;
    mem_u.mem[at[13:2] + 2] = ptr;
    mem_u.mem[at[13:2] + 3] = 32'h0000_0000;
    a = {ptr[31:2], 2'h0};
    off = ptr[1:0];
    rem = cnt;
    while (rem > 0)
    begin
      b = (4 - off < rem) ? 4 - off : rem;
      d = $random(seed);
      mem_u.mem[a[13:2]] = d;
      if (ex) fq.push_back({flags[2] && rem == b, b[2:0], d >> (8 * off)});
      rem -= b;
      off = 0;
      a += 32'h4;
    end
    if (ex && cnt == 13'h0000 && flags[2]) fq.push_back({4'h8, 32'h0});
    if (ex) wq.push_back(at + 32'hC);
    if (cnt == 13'h0000 && !flags[2]) exp_err++;
    if (ex && flags[0]) exp_hi++;
  endtask

  always @(posedge i_clk)
  begin
    if (i_reset_n && f_valid === 1'b1 && ready === 1'b1 && !free_run)
    begin
      e = (fq.size() != 0) ? fq.pop_front() : 36'hF_FFFF_FFFF;
      m = (e[34:32] == 3'h4) ? 32'hFFFF_FFFF : (32'h1 << (8 * e[34:32])) - 32'h1;
      check("fifo entry", {f_fe, f_bytes, f_data & m}, {e[35:32], e[31:0] & m});
    end
    if (wr_req === 1'b1 && wr_ack === 1'b1)
    begin
      w = (wq.size() != 0) ? wq.pop_front() : 32'hFFFF_FFFF;
      check("wb addr", {4'h0, wr_addr}, {4'h0, w});
      check("wb data", {4'h0, wr_data}, 36'h0_4000_0000);
    end
    if (irq_h === 1'b1) seen_hi++;
    if (irq_e === 1'b1) seen_err++;
    if (irq_h !== 1'b0 || irq_e !== 1'b0 || irq !== 1'b0)
      check("irq sum", {35'h0, irq}, {35'h0, irq_h | irq_e});
  end

  task pulse(input int which);
    @(posedge i_clk);
    case (which)
      0: init <= 1'b1;
      1: poll <= 1'b1;
      2: trst <= 1'b1;
      default: last_wr <= 1'b1;
    endcase
    @(posedge i_clk);
    {init, poll, trst, last_wr} <= 4'h0;
  endtask

  task expect_fetch(input logic [31:0] at);
    int k;
    k = 0;
    while (rd_req !== 1'b1 && k < 20)
    begin
      @(posedge i_clk);
      k++;
    end
    check("fetch", {rd_req, rd_len, rd_addr}, {1'b1, 3'h3, at});
    check("cur desc", {4'h0, cur}, {4'h0, at});
  endtask

  task wait_done(input string nm);
    int k;
    k = 0;
    repeat (4) @(posedge i_clk);
    while ((active !== 1'b0 || fq.size() != 0 || wq.size() != 0) && k < 30000)
    begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 30000)
    begin
      n_fail++;
      report_and_stop();
    end
    repeat (6) @(posedge i_clk);
    check("parked", {34'h0, active, rd_req}, 36'h0);
    check("irq host", 36'(seen_hi), 36'(exp_hi));
    check("irq err", 36'(seen_err), 36'(exp_err));
    $display("test %s done", nm);
  endtask

  initial
  begin
    #(8 * 80000);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    stall <= 1'b0;
    pulse(1);
    repeat (8) @(posedge i_clk);
    check("idle poll", {34'h0, active, rd_req}, 36'h0);
    mk_desc(32'h100, 3'h0, 13'h0005, 32'h110, 32'h402, 1);
    mk_desc(32'h110, 3'h7, 13'h000D, 32'h120, 32'h503, 1);
    base <= 32'h100;
    pulse(0);
    expect_fetch(32'h100);
    wait_done("hold list");
    // empty descriptor flags an error, then hold parks again
    mk_desc(32'h120, 3'h2, 13'h0000, 32'h130, 32'h600, 1);
    pulse(1);
    expect_fetch(32'h120);
    wait_done("poll resume");
    // hold set in mode 1 must not stop the list
    mode <= 1'b1;
    last <= 32'h210;
    delay <= 2'h2;
    mk_desc(32'h200, 3'h2, 13'h0004, 32'h210, 32'h700, 1);
    mk_desc(32'h210, 3'h4, 13'h1FFF, 32'h220, 32'h1000, 1);
    stall <= 1'b1;
    base <= 32'h200;
    pulse(0);
    repeat (300) @(posedge i_clk);
    check("full stall", {34'h0, active, rd_req}, 36'h2);
    stall <= 1'b0;
    wait_done("last address");
    mk_desc(32'h220, 3'h4, 13'h0000, 32'h230, 32'h800, 1);
    mk_desc(32'h230, 3'h1, 13'h0003, 32'h240, 32'h805, 1);
    last <= 32'h230;
    pulse(3);
    expect_fetch(32'h220);
    wait_done("new last");
    // transmitter reset in mid-section: complete written, branch address next
    mode <= 1'b0;
    branch <= 32'h300;
    delay <= 2'h0;
    wq.push_back(32'h28C);
    mk_desc(32'h280, 3'h0, 13'h0100, 32'h290, 32'h900, 0);
    free_run = 1'b1;
    base <= 32'h280;
    pulse(0);
    repeat (30) @(posedge i_clk);
    pulse(2);
    repeat (200) @(posedge i_clk);
    check("reset parks", {34'h0, active, f_valid}, 36'h0);
    free_run = 1'b0;
    mk_desc(32'h300, 3'h6, 13'h0002, 32'h310, 32'hA00, 1);
    pulse(1);
    expect_fetch(32'h300);
    wait_done("abort");
    // init while busy: write-back, then straight on at the branch address
    wq.push_back(32'h38C);
    wq.push_back(32'h3AC);
    mk_desc(32'h380, 3'h0, 13'h0100, 32'h390, 32'hB00, 0);
    mk_desc(32'h3A0, 3'h2, 13'h0004, 32'h3B0, 32'hC00, 0);
    free_run = 1'b1;
    base <= 32'h380;
    pulse(0);
    branch <= 32'h3A0;
    repeat (30) @(posedge i_clk);
    pulse(0);
    repeat (200) @(posedge i_clk);
    check("init abort", {1'b0, cur, active, rd_req, f_valid}, {1'b0, 32'h3A0, 3'h0});
    free_run = 1'b0;
    wait_done("init abort");
    report_and_stop();
  end
endmodule
